// *** design/serial_pkg.sv ***
// Shared constants for the asynchronous serial transmit channel and its far-end receiver.
// Assumes both ends run on one 100 MHz clock and see the same bit-rate settings.
package serial_pkg;
  localparam int       DATA_W        = 8;        // Data bits per frame
  localparam int       FIFO_DEPTH    = 8;        // Words held ahead of the shifter
  localparam int       CNT_W         = 16;       // Width of the bit-period counter
  localparam int       DIV_W         = 8;        // Width of the baud divisor
  localparam int       SHIFT_SLOW    = 5;        // Divide by 32 with both selects clear
  localparam int       SHIFT_MID     = 4;        // Divide by 16 with one select set
  localparam int       SHIFT_FAST    = 3;        // Divide by 8 with both selects set
  localparam logic     LINE_IDLE     = 1'b1;     // Idle and stop level of the line
  localparam logic     LINE_START    = 1'b0;     // Start bit level
  localparam logic     OE_N_RESET    = 1'b1;     // Pin not driven after reset
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;   // Index of the final data bit
endpackage

// *** design/serial_link_if.sv ***
// Serial line between the transmit end and the remote receiver.
// The line has a pull-up: while the transmitter does not drive it, it reads high.
`timescale 1ns/1ps
interface serial_link_if;
  logic txd;       // Level the transmitter would drive
  logic txd_oe_n;  // Low while the transmitter drives the line
  logic line;      // Resolved level seen on the wire

  // Pull-up stands in for the undriven pin
  assign line = txd_oe_n ? serial_pkg::LINE_IDLE : txd;

  modport line_driver (output txd, output txd_oe_n);
  modport line_receiver (input line, input txd_oe_n);
endinterface

// *** design/async_tx_end.sv ***
// Transmit end of the asynchronous serial channel: byte FIFO, shifter, request flags.
// Assumes software drives the enable bits, acceptance gates and flag clears as levels
// and pulses synchronous to CLK, and a pulled-up line outside.
`timescale 1ns/1ps

// Byte buffer in front of the shifter; ready is registered so it can leave the block.
module tx_byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  logic          in_ready_r;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready_r;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rptr_r];
  assign in_ready  = in_ready_r;

  // Occupancy after this cycle decides next cycle's ready, so full is never overrun
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wptr_r     <= '0;
      rptr_r     <= '0;
      count_r    <= '0;
      in_ready_r <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      in_ready_r <= (count_nxt < (AW+1)'(D));
      if (push) begin
        wptr_r <= (wptr_r == AW'(D-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(D-1)) ? '0 : rptr_r + 1'b1;
      end
    end
  end

  // Storage, written at the write pointer
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r] <= in_data;
    end
  end
endmodule

// Operation
// - Transmit disabled leaves the output pin undriven.
// - Enable rising edge raises transmit-empty request.
// - Each buffer-to-shifter move raises transmit-empty request.
// - Last stop bit with nothing queued raises finished while the finished enable is set.
// - Disabling transmit clears finished flag, releases pin.
// - Empty interrupt enable clear suppresses empty requests.
// - Software sets enables and empty gate to start.
// - Software writes first byte from empty handler.
// - Last byte: open finished gate, close empty path.
// - Finished handler clears enable, finished enable, gate.
// - New transmission repeats full start sequence.
// - Bit period is 32, 16 or 8 times divisor-plus-one clocks per the speed selects.
module async_tx_end
  import serial_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic               CLK,
  input  wire logic               RESET_N,
  input  wire logic               TRANSMIT_ENABLE_BIT,
  input  wire logic               TX_EMPTY_IRQ_EN,
  input  wire logic               TX_DONE_IRQ_EN,
  input  wire logic               IRQ_ACCEPT_GATE_EMPTY,
  input  wire logic               IRQ_ACCEPT_GATE_DONE,
  input  wire logic               DOUBLE_SPEED_SEL,
  input  wire logic               HALF_SAMPLE_SEL,
  input  wire logic [DIV_W-1:0]   BAUD_DIVISOR,
  input  wire logic [DATA_W-1:0]  WR_DATA,
  input  wire logic               WR_VALID,
  output logic                    WR_READY,
  input  wire logic               CLR_EMPTY_PENDING,
  input  wire logic               CLR_DONE_PENDING,
  output logic                    REQUEST_PENDING_FLAG_EMPTY,
  output logic                    REQUEST_PENDING_FLAG_DONE,
  output logic                    TX_EMPTY_REQUEST,
  output logic                    TX_FINISHED_REQUEST,
  serial_link_if.line_driver      LINK
);
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} tx_state_t;

  tx_state_t          state_r;
  logic [CNT_W-1:0]   tick_cnt_r;
  logic [CNT_W-1:0]   bit_cycles;
  logic [CNT_W-1:0]   div_plus_one;
  logic [2:0]         bit_idx_r;
  logic [DATA_W-1:0]  shift_r;
  logic               txd_r;
  logic               txd_oe_n_r;
  logic               te_d_r;
  logic               empty_pend_r;
  logic               done_pend_r;
  logic               empty_req_r;
  logic               done_req_r;
  logic               fifo_valid;
  logic [DATA_W-1:0]  fifo_data;
  logic               load;
  logic               tick;
  logic               frame_end;
  logic               te;

  assign te = TRANSMIT_ENABLE_BIT;

  // Queue of bytes written by software; the shifter drains it one frame at a time
  tx_byte_fifo #(
    .W (DATA_W),
    .D (DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .in_data   (WR_DATA),
    .in_valid  (WR_VALID),
    .in_ready  (WR_READY),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (load)
  );

  // Bit period: (divisor + 1) scaled by 32, 16 or 8 clocks per the speed selects
  assign div_plus_one = {{(CNT_W-DIV_W){1'b0}}, BAUD_DIVISOR} + CNT_W'(1);
  always_comb begin
    unique case ({DOUBLE_SPEED_SEL, HALF_SAMPLE_SEL})
      2'b00:   bit_cycles = div_plus_one << SHIFT_SLOW;
      2'b11:   bit_cycles = div_plus_one << SHIFT_FAST;
      default: bit_cycles = div_plus_one << SHIFT_MID;
    endcase
  end

  assign tick      = (tick_cnt_r == bit_cycles - CNT_W'(1));
  assign load      = (state_r == ST_IDLE) && te && fifo_valid;
  assign frame_end = (state_r == ST_STOP) && tick;

  // Frame shifter; dropping the enable aborts any frame in flight
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r    <= ST_IDLE;
      tick_cnt_r <= '0;
      bit_idx_r  <= '0;
      shift_r    <= '0;
      txd_r      <= LINE_IDLE;
    end else if (!te) begin
      state_r    <= ST_IDLE;
      tick_cnt_r <= '0;
      txd_r      <= LINE_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          tick_cnt_r <= '0;
          if (fifo_valid) begin
            shift_r <= fifo_data;
            txd_r   <= LINE_START;
            state_r <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            tick_cnt_r <= '0;
            bit_idx_r  <= '0;
            txd_r      <= shift_r[0];
            state_r    <= ST_DATA;
          end else begin
            tick_cnt_r <= tick_cnt_r + CNT_W'(1);
          end
        end
        ST_DATA: begin
          if (tick) begin
            tick_cnt_r <= '0;
            if (bit_idx_r == LAST_BIT_IDX) begin
              txd_r   <= LINE_IDLE;
              state_r <= ST_STOP;
            end else begin
              bit_idx_r <= bit_idx_r + 3'h1;
              shift_r   <= shift_r >> 1;
              txd_r     <= shift_r[1];
            end
          end else begin
            tick_cnt_r <= tick_cnt_r + CNT_W'(1);
          end
        end
        ST_STOP: begin
          if (tick) begin
            tick_cnt_r <= '0;
            state_r    <= ST_IDLE;
          end else begin
            tick_cnt_r <= tick_cnt_r + CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Pin drive follows the enable; a pull-up holds the line while released
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      txd_oe_n_r <= OE_N_RESET;
      te_d_r     <= 1'b0;
    end else begin
      txd_oe_n_r <= !te;
      te_d_r     <= te;
    end
  end

  // Empty flag: set on enable rise and on each load while the empty enable is set; set beats a same-cycle clear
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      empty_pend_r <= 1'b0;
    end else if (TX_EMPTY_IRQ_EN && ((te && !te_d_r) || load)) begin
      empty_pend_r <= 1'b1;
    end else if (CLR_EMPTY_PENDING) begin
      empty_pend_r <= 1'b0;
    end
  end

  // Finished flag: last stop bit with an empty queue and the finished enable set; disabling transmit clears it.
  // A frame cut short by the disable never counts as finished, so the clear holds.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      done_pend_r <= 1'b0;
    end else if (frame_end && te && !fifo_valid && TX_DONE_IRQ_EN) begin
      done_pend_r <= 1'b1;
    end else if (CLR_DONE_PENDING || !te) begin
      done_pend_r <= 1'b0;
    end
  end

  // Requests reach the processor only through its enables and acceptance gates,
  // so the start, last-byte and finish handler sequences steer them
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      empty_req_r <= 1'b0;
      done_req_r  <= 1'b0;
    end else begin
      empty_req_r <= empty_pend_r && TX_EMPTY_IRQ_EN && IRQ_ACCEPT_GATE_EMPTY;
      done_req_r  <= done_pend_r && TX_DONE_IRQ_EN && IRQ_ACCEPT_GATE_DONE;
    end
  end

  assign REQUEST_PENDING_FLAG_EMPTY = empty_pend_r;
  assign REQUEST_PENDING_FLAG_DONE  = done_pend_r;
  assign TX_EMPTY_REQUEST           = empty_req_r;
  assign TX_FINISHED_REQUEST        = done_req_r;
  assign LINK.txd                   = txd_r;
  assign LINK.txd_oe_n              = txd_oe_n_r;
endmodule

// *** design/async_rx_end.sv ***
// Remote receiver end: recovers bytes from the resolved serial line.
// Assumes the same clock as the transmitter and a bit period given in clocks.
`timescale 1ns/1ps
module async_rx_end
  import serial_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  input  wire logic [CNT_W-1:0]  BIT_CYCLES,
  output logic [DATA_W-1:0]      RX_DATA,
  output logic                   RX_VALID,
  output logic                   RX_FRAME_ERR,
  serial_link_if.line_receiver   LINK
);
  typedef enum logic [1:0] {RS_IDLE, RS_START, RS_DATA, RS_STOP} rx_state_t;

  rx_state_t          state_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [2:0]         bit_idx_r;
  logic [DATA_W-1:0]  shift_r;
  logic [DATA_W-1:0]  data_r;
  logic               valid_r;
  logic               ferr_r;
  logic               full_bit;
  logic               half_bit;

  // Sampling lands mid-bit: half a period after the start edge, then whole periods
  assign full_bit = (cnt_r == BIT_CYCLES - CNT_W'(1));
  assign half_bit = (cnt_r == (BIT_CYCLES >> 1) - CNT_W'(1));

  // Frame recovery: start low, eight bits LSB first, one high stop
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r   <= RS_IDLE;
      cnt_r     <= '0;
      bit_idx_r <= '0;
      shift_r   <= '0;
      data_r    <= '0;
      valid_r   <= 1'b0;
      ferr_r    <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      ferr_r  <= 1'b0;
      unique case (state_r)
        RS_IDLE: begin
          cnt_r <= '0;
          if (LINK.line == LINE_START) begin
            state_r <= RS_START;
          end
        end
        RS_START: begin
          if (half_bit) begin
            cnt_r <= '0;
            // A glitch shorter than half a bit is not a start bit
            state_r   <= (LINK.line == LINE_START) ? RS_DATA : RS_IDLE;
            bit_idx_r <= '0;
          end else begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
        RS_DATA: begin
          if (full_bit) begin
            cnt_r   <= '0;
            shift_r <= {LINK.line, shift_r[DATA_W-1:1]};
            if (bit_idx_r == LAST_BIT_IDX) begin
              state_r <= RS_STOP;
            end else begin
              bit_idx_r <= bit_idx_r + 3'h1;
            end
          end else begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
        RS_STOP: begin
          if (full_bit) begin
            cnt_r   <= '0;
            state_r <= RS_IDLE;
            if (LINK.line == LINE_IDLE) begin
              data_r  <= shift_r;
              valid_r <= 1'b1;
            end else begin
              ferr_r <= 1'b1;
            end
          end else begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
      endcase
    end
  end

  assign RX_DATA      = data_r;
  assign RX_VALID     = valid_r;
  assign RX_FRAME_ERR = ferr_r;
endmodule

// *** verification/async_serial_tx_irq_flow_asserts.sv ***
// Checker of the serial link and the request outputs of the transmit channel.
// Assumes the bench places it beside the link interface; one clock domain.
`timescale 1ns/1ps
module async_serial_tx_irq_flow_asserts (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [15:0] BIT_CLKS,
  input wire logic TRANSMIT_ENABLE_BIT,
  input wire logic TX_EMPTY_IRQ_EN,
  input wire logic TX_DONE_IRQ_EN,
  input wire logic IRQ_ACCEPT_GATE_EMPTY,
  input wire logic IRQ_ACCEPT_GATE_DONE,
  input wire logic REQUEST_PENDING_FLAG_EMPTY,
  input wire logic REQUEST_PENDING_FLAG_DONE,
  input wire logic TX_EMPTY_REQUEST,
  input wire logic TX_FINISHED_REQUEST,
  input wire logic RX_FRAME_ERR,
  input wire logic txd_oe_n,
  input wire logic line
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  logic        line_d_r;
  logic [15:0] run_r;

  // Clocks the line has stood at its level; wraps only after a very long idle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      line_d_r <= 1'b1;
      run_r    <= '0;
    end else begin
      line_d_r <= line;
      run_r    <= (line != line_d_r) ? 16'h0001 : run_r + 16'h0001;
    end
  end

  // Enable edge with the empty interrupt on, answered by the flag and a driven pin
  sequence enable_step;
    $rose(TRANSMIT_ENABLE_BIT) && TX_EMPTY_IRQ_EN;
  endsequence
  sequence enable_answer;
    REQUEST_PENDING_FLAG_EMPTY && !txd_oe_n;
  endsequence

  AST_RELEASE_WHEN_OFF: assert property (!TRANSMIT_ENABLE_BIT |=> txd_oe_n && line)
    else $error("line still driven with transmit off");
  AST_DRIVE_NEEDS_ENABLE: assert property (!txd_oe_n |-> $past(TRANSMIT_ENABLE_BIT))
    else $error("line driven without enable");
  AST_ENABLE_RAISES_EMPTY: assert property (enable_step |=> enable_answer)
    else $error("no empty flag after enable");
  AST_DONE_CLEARED_OFF: assert property (!TRANSMIT_ENABLE_BIT |=> !REQUEST_PENDING_FLAG_DONE)
    else $error("finished flag kept with transmit off");
  AST_EMPTY_SUPPRESSED: assert property (!TX_EMPTY_IRQ_EN |=> !TX_EMPTY_REQUEST)
    else $error("empty request while its enable is clear");
  AST_EMPTY_REQ_FOLLOWS: assert property (REQUEST_PENDING_FLAG_EMPTY && TX_EMPTY_IRQ_EN
    && IRQ_ACCEPT_GATE_EMPTY |=> TX_EMPTY_REQUEST)
    else $error("empty request missing");
  AST_DONE_REQ_FOLLOWS: assert property (REQUEST_PENDING_FLAG_DONE && TX_DONE_IRQ_EN
    && IRQ_ACCEPT_GATE_DONE |=> TX_FINISHED_REQUEST)
    else $error("finished request missing");
  // Finished only after a whole high stop bit, and only when enabled
  AST_DONE_AFTER_STOP: assert property ($rose(REQUEST_PENDING_FLAG_DONE) |->
    $past(line) && (run_r >= BIT_CLKS) && $past(TX_DONE_IRQ_EN))
    else $error("finished flag without a stop bit");
  // Low stretches are start plus zero bits only, so they last whole bit periods
  AST_LOW_RUN_WHOLE_BITS: assert property ($rose(line) |-> (run_r % BIT_CLKS) == 16'h0000)
    else $error("low level not a whole number of bit periods");
  AST_NO_FRAME_ERR: assert property (!RX_FRAME_ERR)
    else $error("receiver saw a low stop bit");
endmodule

// *** verification/async_serial_tx_irq_flow_tb.sv ***
// Bench joining transmit and receive ends through the link interface.
// Assumes divisor 0: bits last 32 clocks, then 16 once the double-speed select is set.
`timescale 1ns/1ps
module async_serial_tx_irq_flow_tb
  import serial_pkg::*;
;
  logic              clk = 1'b0, reset_n = 1'b0, te = 1'b0, ie_e = 1'b0, ie_d = 1'b0;
  logic              g_e = 1'b0, g_d = 1'b0, clr_e = 1'b0, wr_valid = 1'b0, dbl = 1'b0;
  logic [15:0]       bit_len = 16'h0020;
  logic [DATA_W-1:0] wr_data = 8'h00;
  logic              wr_ready, flag_e, flag_d, req_e, req_d, rx_valid, rx_err;
  logic [DATA_W-1:0] rx_data;
  logic [DATA_W-1:0] exp_q[$];
  int                num_errors = 0, comparisons = 0, seed = 23;

  always #5 clk = ~clk;
  serial_link_if u_serial_link_if ();
  async_tx_end #(.DEPTH(FIFO_DEPTH)) u_async_tx_end (
    .CLK(clk), .RESET_N(reset_n), .TRANSMIT_ENABLE_BIT(te), .TX_EMPTY_IRQ_EN(ie_e),
    .TX_DONE_IRQ_EN(ie_d), .IRQ_ACCEPT_GATE_EMPTY(g_e), .IRQ_ACCEPT_GATE_DONE(g_d),
    .DOUBLE_SPEED_SEL(dbl), .HALF_SAMPLE_SEL(1'b0), .BAUD_DIVISOR(8'h00),
    .WR_DATA(wr_data), .WR_VALID(wr_valid), .WR_READY(wr_ready),
    .CLR_EMPTY_PENDING(clr_e), .CLR_DONE_PENDING(1'b0),
    .REQUEST_PENDING_FLAG_EMPTY(flag_e), .REQUEST_PENDING_FLAG_DONE(flag_d),
    .TX_EMPTY_REQUEST(req_e), .TX_FINISHED_REQUEST(req_d), .LINK(u_serial_link_if));
  async_rx_end u_async_rx_end (.CLK(clk), .RESET_N(reset_n), .BIT_CYCLES(bit_len),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_FRAME_ERR(rx_err), .LINK(u_serial_link_if));
  async_serial_tx_irq_flow_asserts u_async_serial_tx_irq_flow_asserts (
    .CLK(clk), .RESET_N(reset_n), .BIT_CLKS(bit_len), .TRANSMIT_ENABLE_BIT(te),
    .TX_EMPTY_IRQ_EN(ie_e),
    .TX_DONE_IRQ_EN(ie_d), .IRQ_ACCEPT_GATE_EMPTY(g_e), .IRQ_ACCEPT_GATE_DONE(g_d),
    .REQUEST_PENDING_FLAG_EMPTY(flag_e), .REQUEST_PENDING_FLAG_DONE(flag_d),
    .TX_EMPTY_REQUEST(req_e), .TX_FINISHED_REQUEST(req_d), .RX_FRAME_ERR(rx_err),
    .txd_oe_n(u_serial_link_if.txd_oe_n), .line(u_serial_link_if.line));

  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Bounded wait on a request level, looked at where registers have settled
  task automatic wait_lvl(input bit which, input logic lvl);
    for (int n = 0; n < 5000; n++) begin
      @(negedge clk);
      if ((which ? req_d : req_e) === lvl) return;
    end
    num_errors++;
    $display("MISMATCH at %0t: request wait ran out", $time);
    give_verdict();
  endtask

  // One write; a byte is expected on the line only if the buffer took it
  task automatic write_byte(input logic [7:0] b, input bit take);
    @(posedge clk);
    wr_data <= b;
    wr_valid <= 1'b1;
    @(negedge clk);
    check({7'h00, wr_ready}, {7'h00, take}, "write ready");
    if (take) exp_q.push_back(b);
    @(posedge clk);
    wr_valid <= 1'b0;
  endtask

  task automatic pulse_clear();
    @(posedge clk);
    clr_e <= 1'b1;
    @(posedge clk);
    clr_e <= 1'b0;
  endtask

  // Start sequence: enables and empty gate together, then the flag must follow
  task automatic start_tx();
    @(posedge clk);
    te <= 1'b1; ie_e <= 1'b1; ie_d <= 1'b1; g_e <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check({7'h00, flag_e}, 8'h01, "empty flag on enable");
  endtask

  task automatic last_byte_gates();
    @(posedge clk);
    ie_e <= 1'b0; g_e <= 1'b0; g_d <= 1'b1;
  endtask

  // Finished handler: wait for the end request, switch off, check the pin lets go
  task automatic finish_tx();
    wait_lvl(1'b1, 1'b1);
    check({7'h00, flag_d}, 8'h01, "finished flag");
    check({7'h00, flag_e}, 8'h00, "empty flag after last byte");
    @(posedge clk);
    te <= 1'b0; ie_d <= 1'b0; g_d <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({5'h00, flag_d, u_serial_link_if.txd_oe_n, u_serial_link_if.line}, 8'h03,
      "pin release");
    repeat (40) @(posedge clk);
    check(8'(exp_q.size()), 8'h00, "bytes still owed");
  endtask

  // Receiver watch: each recovered byte must be the oldest one written
  // Looked at on the falling edge, while the one-cycle valid pulse stands
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) check(8'h01, 8'h00, "byte not expected");
      else check(rx_data, exp_q.pop_front(), "received byte");
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({7'h00, u_serial_link_if.txd_oe_n}, 8'h01, "pin off after reset");
    // Handler-paced transfer: the first byte only after the enable request
    start_tx();
    for (int i = 0; i < 3; i++) begin
      wait_lvl(1'b0, 1'b1);
      pulse_clear();
      if (i == 2) last_byte_gates();
      write_byte(8'($random(seed)), 1'b1);
    end
    finish_tx();
    // Fill while off until refused, then restart and drain all at once
    for (int i = 0; i < FIFO_DEPTH; i++) write_byte(8'($random(seed)), 1'b1);
    write_byte(8'hA5, 1'b0);
    start_tx();
    last_byte_gates();
    pulse_clear();
    finish_tx();
    // One speed select set halves the bit to 16 clocks; the receiver is told the same
    @(posedge clk);
    dbl <= 1'b1;
    bit_len <= 16'h0010;
    for (int i = 0; i < 2; i++) write_byte(8'($random(seed)), 1'b1);
    start_tx();
    last_byte_gates();
    pulse_clear();
    finish_tx();
    give_verdict();
  end
endmodule
